// ==== cfg_word_pkg.sv ====
package cfg_word_pkg;

   // Register byte offsets on the bus
   localparam logic [4:0] OFS_WORD_TWO      = 5'h00;
   localparam logic [4:0] OFS_WORD_PROTECT  = 5'h04;
   localparam logic [4:0] OFS_WORD_LOWPOWER = 5'h08;
   localparam logic [4:0] OFS_STATUS        = 5'h0C;
   localparam logic [4:0] OFS_CONTROL       = 5'h10;

   // Index of each word in nonvolatile storage
   localparam logic [1:0] IDX_WORD_TWO      = 2'h1;
   localparam logic [1:0] IDX_WORD_PROTECT  = 2'h2;
   localparam logic [1:0] IDX_WORD_LOWPOWER = 2'h3;

   // Erased values used until the first load completes
   localparam logic [15:0] RST_WORD_TWO      = 16'hFFFB;
   localparam logic [15:0] RST_WORD_PROTECT  = 16'hFFFF;
   localparam logic [15:0] RST_WORD_LOWPOWER = 16'hFFFF;
   localparam logic [7:0]  UNIMPL_UPPER      = 8'hFF;

   // Word two field positions
   localparam int P_WDT_MUX    = 13;
   localparam int P_CLKOUT_SEL = 5;
   localparam int P_WDT_CLK    = 3;
   localparam int P_POSC_MODE  = 0;
   // Word protect field positions
   localparam int P_SEG_END    = 15;
   localparam int P_CFG_PROT   = 14;
   localparam int P_SEG_DIS    = 13;
   localparam int P_BOR_EN     = 12;
   localparam int P_WIN_WIDTH  = 9;
   localparam int P_SECONDARY_OSC_SEL   = 8;
   localparam int P_BOUNDARY   = 0;
   // Word lowpower field positions
   localparam int P_ONEWAY     = 15;
   localparam int P_I2C_ROUTE  = 14;
   localparam int P_PLL_DIV    = 10;
   localparam int P_RTC_BAT    = 9;
   localparam int P_DS_SWCTL   = 8;
   localparam int P_DSWDT_EN   = 7;
   localparam int P_DS_BOR     = 6;
   localparam int P_DSWDT_CLK  = 5;
   localparam int P_DSWDT_PS   = 0;
   // Control and status bit positions
   localparam int P_CTL_DS_REQ = 0;
   localparam int P_CTL_LOCK   = 1;
   localparam int P_STS_LOADED = 0;
   localparam int P_STS_LOCK   = 1;

   // Page geometry of program memory
   localparam logic [6:0] LAST_PAGE      = 7'h7F;
   localparam int         PAGE_WORD_BITS = 9;
   localparam logic [5:0] DSWDT_EXP_BASE = 6'h05;

   typedef enum logic [1:0] {POSC_EXT_CLOCK, POSC_STD_XTAL, POSC_HS_XTAL, POSC_OFF} posc_mode_t;
   typedef enum logic [1:0] {PIN_PORT_IO, PIN_INSTR_CLOCK, PIN_OSCILLATOR} clkout_mode_t;
   typedef enum logic [1:0] {WCLK_LOW_POWER_RC, WCLK_FAST_RC, WCLK_SECONDARY, WCLK_SYSTEM}
      wdt_clock_t;
   typedef enum logic [1:0] {PH_FETCH, PH_WAIT, PH_RUN} load_phase_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [4:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      clkout_mode_t clkout_pin_select;
      wdt_clock_t   watchdog_clock;
      posc_mode_t   primary_osc_mode;
      logic         secondary_osc_crystal;
      logic         secondary_clock_digital;
      logic         brownout_active;
      logic [2:0]   window_eighths;
   } osc_cfg_t;

   typedef struct packed {
      logic        segment_enable;
      logic [23:0] segment_low_addr;
      logic [23:0] segment_high_addr;
      logic        config_page_locked;
   } protect_cfg_t;

   typedef struct packed {
      logic       pinselect_oneway_lock;
      logic       pinselect_lock;
      logic       i2c_two_pin_route;
      logic       pll_enable;
      logic       pll_reserved;
      logic [3:0] pll_divisor;
      logic       battery_rtc_run;
      logic       deep_sleep_allowed;
      logic       deep_sleep_wdog_enable;
      logic       deep_sleep_wdog_low_power_rc_osc;
      logic [5:0] deep_sleep_wdog_exp;
   } lowpwr_cfg_t;

endpackage

// ==== config_word_decoder.sv ====
// What this block does
// R1 - Reload all words each reset before use
// R2 - Modes 11/00: pin gives Fosc/2 or port
// R3 - Modes 10/01: pin belongs to oscillator
// R4 - Mux on: select field picks watchdog clock
// R5 - Mux off: watchdog always on low-power RC
// R6 - Code 10: fast RC if windowed, awake and system clock not LOW_POWER_RC_OSC, else LOW_POWER_RC_OSC
// R7 - Decode primary oscillator mode field
// R8 - End select sets segment bounds from boundary
// R9 - Config page protect needs segment enabled
// R10 - End select or last boundary protects config
// R11 - Boundary is page of 512 words
// R12 - Brown-out enable outside deep sleep
// R13 - Window width 25/37.5/50/75 percent
// R14 - Secondary crystal or digital clock input
// R15 - One-way lock blocks clearing pin-select lock
// R16 - I2C route bit, forced 1 on small package
// R17 - PLL prescaler decode to 4 MHz input
// R18 - RTC runs on battery when bit set
// R19 - Deep sleep only with software control bit
// R20 - Deep sleep watchdog enable and clock
// R21 - Deep sleep brown-out bit
// R22 - Deep sleep postscale exponent code plus five
// R23 - Upper byte of each word reads ones
// R24 - Stored words held until next reset
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
module config_word_decoder (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire cfg_word_pkg::wb_req_t       wb_req_i,
   output      cfg_word_pkg::wb_rsp_t       wb_rsp_o,
   output      logic                        nvm_req_o,
   output      logic [1:0]                  nvm_index_o,
   input  wire logic                        nvm_ack_i,
   input  wire logic [23:0]                 nvm_data_i,
   input  wire logic                        large_package_i,
   input  wire logic                        sleep_i,
   input  wire logic                        deep_sleep_i,
   input  wire logic                        windowed_wdt_i,
   input  wire logic                        sysclk_is_low_power_rc_osc_i,
   input  wire logic                        pps_unlocked_i,
   output      logic                        config_valid_o,
   output      cfg_word_pkg::osc_cfg_t      osc_cfg_o,
   output      cfg_word_pkg::protect_cfg_t  protect_cfg_o,
   output      cfg_word_pkg::lowpwr_cfg_t   lowpwr_cfg_o
);
   import cfg_word_pkg::*;

   typedef struct packed {
      load_phase_t  phase;
      logic [1:0]   index;
      logic [15:0]  word_two;
      logic [15:0]  word_protect;
      logic [15:0]  word_lowpower;
      logic         loaded;
      logic         nvm_req;
      logic         pkg_meta;
      logic         pkg_sync;
      logic         large_pkg;
      logic         ds_request;
      wb_rsp_t      rsp;
      osc_cfg_t     osc;
      protect_cfg_t prot;
      lowpwr_cfg_t  lowp;
   } state_t;

   state_t st;
   state_t next_st;

   // Primary oscillator mode decode
   function automatic posc_mode_t posc_decode(input logic [1:0] code);
      unique case (code)
         2'b11:   posc_decode = POSC_OFF;
         2'b10:   posc_decode = POSC_HS_XTAL;
         2'b01:   posc_decode = POSC_STD_XTAL;
         default: posc_decode = POSC_EXT_CLOCK;
      endcase
   endfunction

   // Open window width in eighths of the period
   function automatic logic [2:0] window_decode(input logic [1:0] code);
      unique case (code)
         2'b11:   window_decode = 3'h2;
         2'b10:   window_decode = 3'h3;
         2'b01:   window_decode = 3'h4;
         default: window_decode = 3'h6;
      endcase
   endfunction

   // Prescaler divisor for a 4 MHz PLL input, zero where unused
   function automatic logic [3:0] pll_divisor(input logic [3:0] code);
      unique case (code)
         4'h7:    pll_divisor = 4'hC;
         4'h6:    pll_divisor = 4'h8;
         4'h5:    pll_divisor = 4'h6;
         4'h4:    pll_divisor = 4'h5;
         4'h3:    pll_divisor = 4'h4;
         4'h2:    pll_divisor = 4'h3;
         4'h1:    pll_divisor = 4'h2;
         4'h0:    pll_divisor = 4'h1;
         default: pll_divisor = 4'h0;
      endcase
   endfunction

   // Page number to first word address of that page
   function automatic logic [23:0] page_base(input logic [6:0] page);
      page_base = {8'h00, page, 9'h000};
   endfunction

   // Bus read view of a stored word, unimplemented byte reads ones
   function automatic logic [31:0] word_view(input logic [15:0] w);
      word_view = {8'h00, UNIMPL_UPPER, w}; // [R23]
   endfunction

   logic [1:0] posc_f;
   logic [1:0] wclk_f;
   logic [6:0] bound_f;
   logic       bus_hit;
   logic       bus_write;

   // Field slices of the stored words
   assign posc_f    = st.word_two[P_POSC_MODE +: 2];
   assign wclk_f    = st.word_two[P_WDT_CLK +: 2];
   assign bound_f   = st.word_protect[P_BOUNDARY +: 7];
   assign bus_hit   = wb_req_i.cyc & wb_req_i.stb & ~st.rsp.ack;
   assign bus_write = bus_hit & wb_req_i.we;

   // Next-state logic: loader, decode, bus slave
   always_comb begin
      next_st = st;

      // Strap synchroniser, sampled once the words are in
      next_st.pkg_meta = large_package_i;
      next_st.pkg_sync = st.pkg_meta;

      // Load sequence reads each word once per reset
      unique case (st.phase)
         PH_FETCH: begin
            next_st.phase = PH_WAIT;
         end
         PH_WAIT: begin
            if (nvm_ack_i) begin
               unique case (st.index)
                  IDX_WORD_TWO:     next_st.word_two      = nvm_data_i[15:0]; // [R1]
                  IDX_WORD_PROTECT: next_st.word_protect  = nvm_data_i[15:0]; // [R1]
                  default:          next_st.word_lowpower = nvm_data_i[15:0]; // [R1]
               endcase
               if (st.index == IDX_WORD_LOWPOWER) begin
                  next_st.phase     = PH_RUN;
                  next_st.large_pkg = st.pkg_sync;
               end else begin
                  next_st.index = st.index + 2'h1;
                  next_st.phase = PH_FETCH;
               end
            end
         end
         PH_RUN: begin
            next_st.phase  = PH_RUN; // Words frozen until the next reset [R24]
            next_st.loaded = 1'b1; // Valid only once outputs show the last word [R1]
         end
      endcase
      next_st.nvm_req = (next_st.phase == PH_WAIT); // Request straight from a flop

      // Clock-out pin use
      if (posc_f == 2'b10 || posc_f == 2'b01) begin
         next_st.osc.clkout_pin_select = PIN_OSCILLATOR; // [R3]
      end else if (st.word_two[P_CLKOUT_SEL]) begin
         next_st.osc.clkout_pin_select = PIN_INSTR_CLOCK; // [R2]
      end else begin
         next_st.osc.clkout_pin_select = PIN_PORT_IO; // [R2]
      end

      // Watchdog clock source, follows sleep and system clock state
      if (!st.word_two[P_WDT_MUX]) begin
         next_st.osc.watchdog_clock = WCLK_LOW_POWER_RC; // [R5]
      end else begin
         unique case (wclk_f)
            2'b11: next_st.osc.watchdog_clock = WCLK_LOW_POWER_RC; // [R4]
            2'b10: begin
               if (windowed_wdt_i && !sysclk_is_low_power_rc_osc_i && !sleep_i) begin
                  next_st.osc.watchdog_clock = WCLK_FAST_RC; // [R6]
               end else begin
                  next_st.osc.watchdog_clock = WCLK_LOW_POWER_RC; // [R6]
               end
            end
            2'b01: next_st.osc.watchdog_clock = WCLK_SECONDARY; // [R4]
            2'b00: begin
               next_st.osc.watchdog_clock = sleep_i ? WCLK_LOW_POWER_RC
                                                    : WCLK_SYSTEM; // [R4]
            end
         endcase
      end

      next_st.osc.primary_osc_mode = posc_decode(posc_f); // [R7]

      // Secondary oscillator circuit or digital clock input
      next_st.osc.secondary_osc_crystal   = st.word_protect[P_SECONDARY_OSC_SEL]; // [R14]
      next_st.osc.secondary_clock_digital = ~st.word_protect[P_SECONDARY_OSC_SEL]; // [R14]

      // Brown-out: main enable outside deep sleep, own bit inside
      if (deep_sleep_i) begin
         next_st.osc.brownout_active = st.word_lowpower[P_DS_BOR]; // [R21]
      end else begin
         next_st.osc.brownout_active = st.word_protect[P_BOR_EN]; // [R12]
      end

      next_st.osc.window_eighths = window_decode(st.word_protect[P_WIN_WIDTH +: 2]); // [R13]

      // Protected segment bounds in word addresses
      next_st.prot.segment_enable = ~st.word_protect[P_SEG_DIS]; // [R9]
      if (st.word_protect[P_SEG_END]) begin
         next_st.prot.segment_low_addr  = page_base(bound_f); // [R8] [R11]
         next_st.prot.segment_high_addr = page_base(LAST_PAGE)
                                          | 24'h0001FF; // [R8]
      end else begin
         next_st.prot.segment_low_addr  = 24'h000000; // [R8]
         next_st.prot.segment_high_addr = page_base(bound_f) | 24'h0001FF; // [R8] [R11]
      end

      // Configuration page lock
      next_st.prot.config_page_locked = ~st.word_protect[P_SEG_DIS]
                                        & (~st.word_protect[P_CFG_PROT] // [R9]
                                           | st.word_protect[P_SEG_END] // [R10]
                                           | (bound_f == LAST_PAGE)); // [R10]

      // Pin routing and PLL prescaler
      next_st.lowp.pinselect_oneway_lock = st.word_lowpower[P_ONEWAY]; // [R15]
      next_st.lowp.i2c_two_pin_route     = st.large_pkg ? st.word_lowpower[P_I2C_ROUTE]
                                                        : 1'b1; // [R16]
      next_st.lowp.pll_divisor  = pll_divisor(st.word_lowpower[P_PLL_DIV +: 4]); // [R17]
      next_st.lowp.pll_enable   = st.word_lowpower[P_PLL_DIV +: 4] != 4'hF; // [R17]
      next_st.lowp.pll_reserved = st.word_lowpower[P_PLL_DIV + 3]
                                  & (st.word_lowpower[P_PLL_DIV +: 4] != 4'hF); // [R17]

      // Battery, deep sleep and deep sleep watchdog
      next_st.lowp.battery_rtc_run    = st.word_lowpower[P_RTC_BAT]; // [R18]
      next_st.lowp.deep_sleep_allowed = st.word_lowpower[P_DS_SWCTL]
                                        & st.ds_request; // [R19]
      next_st.lowp.deep_sleep_wdog_enable = st.word_lowpower[P_DSWDT_EN]; // [R20]
      next_st.lowp.deep_sleep_wdog_low_power_rc_osc   = st.word_lowpower[P_DSWDT_CLK]; // [R20]
      next_st.lowp.deep_sleep_wdog_exp    = {1'b0, st.word_lowpower[P_DSWDT_PS +: 5]}
                                            + DSWDT_EXP_BASE; // [R22]

      // Bus slave: one-cycle ack, every address answered
      next_st.rsp.ack = bus_hit;
      next_st.rsp.dat = 32'h00000000;
      if (bus_hit && !wb_req_i.we) begin
         unique case (wb_req_i.adr)
            OFS_WORD_TWO:      next_st.rsp.dat = word_view(st.word_two);
            OFS_WORD_PROTECT:  next_st.rsp.dat = word_view(st.word_protect);
            OFS_WORD_LOWPOWER: next_st.rsp.dat = word_view(st.word_lowpower);
            OFS_STATUS: begin
               next_st.rsp.dat[P_STS_LOADED] = st.loaded;
               next_st.rsp.dat[P_STS_LOCK]   = st.lowp.pinselect_lock;
            end
            OFS_CONTROL: begin
               next_st.rsp.dat[P_CTL_DS_REQ] = st.ds_request;
               next_st.rsp.dat[P_CTL_LOCK]   = st.lowp.pinselect_lock;
            end
            default: next_st.rsp.dat = 32'h00000000;
         endcase
      end

      // Control writes: deep sleep request and pin-select lock
      if (bus_write && wb_req_i.adr == OFS_CONTROL && wb_req_i.sel[0]) begin
         next_st.ds_request = wb_req_i.dat[P_CTL_DS_REQ];
         if (pps_unlocked_i && st.loaded) begin
            if (wb_req_i.dat[P_CTL_LOCK]) begin
               next_st.lowp.pinselect_lock = 1'b1; // [R15]
            end else if (!st.word_lowpower[P_ONEWAY]) begin
               next_st.lowp.pinselect_lock = 1'b0; // [R15]
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st               <= '0;
         st.phase         <= PH_FETCH;
         st.index         <= IDX_WORD_TWO;
         st.word_two      <= RST_WORD_TWO;
         st.word_protect  <= RST_WORD_PROTECT;
         st.word_lowpower <= RST_WORD_LOWPOWER;
         st.large_pkg     <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state; decoded values not gated by load done
   assign wb_rsp_o       = st.rsp;
   assign nvm_req_o      = st.nvm_req;
   assign nvm_index_o    = st.index;
   assign config_valid_o = st.loaded; // [R1]
   assign osc_cfg_o      = st.osc;
   assign protect_cfg_o  = st.prot;
   assign lowpwr_cfg_o   = st.lowp;

endmodule

// ==== config_word_decoder_sva.sv ====
`timescale 1ns/1ns
module config_word_decoder_sva (
   input wire logic                       clk_i,
   input wire logic                       rst_i,
   input wire cfg_word_pkg::wb_req_t      wb_req_i,
   input wire cfg_word_pkg::wb_rsp_t      wb_rsp_o,
   input wire logic                       nvm_req_o,
   input wire logic [1:0]                 nvm_index_o,
   input wire logic                       nvm_ack_i,
   input wire logic                       sleep_i,
   input wire logic                       config_valid_o,
   input wire cfg_word_pkg::osc_cfg_t     osc_cfg_o,
   input wire cfg_word_pkg::protect_cfg_t protect_cfg_o,
   input wire cfg_word_pkg::lowpwr_cfg_t  lowpwr_cfg_o
);
   import cfg_word_pkg::*;
   // Short names for the bus handshake and the config valid flag
   wire bus_req = wb_req_i.cyc && wb_req_i.stb;
   wire ack     = wb_rsp_o.ack;
   wire valid   = config_valid_o;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property ((bus_req && !ack) |=> ack)
      else $error("bus request not answered next cycle");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_load_order: assert property ($rose(valid) |->
      $past(nvm_ack_i, 2) && $past(nvm_index_o, 2) == 2'h3)
      else $error("valid without final word load");
   a_nvm_hold: assert property (nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_index_o))
      else $error("word request dropped early");
   a_pin_owner: assert property ((osc_cfg_o.primary_osc_mode inside {POSC_HS_XTAL, POSC_STD_XTAL})
      == (osc_cfg_o.clkout_pin_select == PIN_OSCILLATOR)) else $error("pin owner wrong");
   a_sleep_wdt: assert property (valid && sleep_i |=>
      osc_cfg_o.watchdog_clock inside {WCLK_LOW_POWER_RC, WCLK_SECONDARY})
      else $error("watchdog clock wrong in sleep");
   a_window_code: assert property (valid |-> osc_cfg_o.window_eighths inside {3'h2, 3'h3, 3'h4, 3'h6})
      else $error("window width code wrong");
   a_seg_bounds: assert property (valid && protect_cfg_o.segment_enable |->
      protect_cfg_o.segment_low_addr[8:0] == 9'h000 && protect_cfg_o.segment_high_addr[8:0] == 9'h1FF
      && (protect_cfg_o.segment_low_addr == 24'h0 || protect_cfg_o.segment_high_addr == 24'h00FFFF))
      else $error("segment bounds wrong");
   a_cfg_lock_seg: assert property (protect_cfg_o.config_page_locked |-> protect_cfg_o.segment_enable)
      else $error("config page locked with segments off");
   a_pll_reserved: assert property (lowpwr_cfg_o.pll_reserved |-> lowpwr_cfg_o.pll_divisor == 4'h0)
      else $error("reserved prescale has divisor");
   a_ds_exp: assert property (valid |-> lowpwr_cfg_o.deep_sleep_wdog_exp inside {[6'h05:6'h24]})
      else $error("postscale exponent out of range");
   a_held_config: assert property (valid && $past(valid) |=> valid && $stable(protect_cfg_o))
      else $error("decoded settings changed");
endmodule

bind config_word_decoder config_word_decoder_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .nvm_req_o(nvm_req_o), .nvm_index_o(nvm_index_o),
   .nvm_ack_i(nvm_ack_i), .sleep_i(sleep_i), .config_valid_o(config_valid_o),
   .osc_cfg_o(osc_cfg_o), .protect_cfg_o(protect_cfg_o), .lowpwr_cfg_o(lowpwr_cfg_o));

// ==== config_word_decoder_tb.sv ====
`timescale 1ns/1ns
module config_word_decoder_tb;
   import cfg_word_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   wb_req_t      wb_req_i = '0;
   wb_rsp_t      wb_rsp_o;
   logic         nvm_req_o;
   logic [1:0]   nvm_index_o;
   logic         nvm_ack_i = 1'b0;
   logic [23:0]  nvm_data_i = '0;
   logic         large_package_i = 1'b1;
   logic         sleep_i = 1'b0;
   logic         deep_sleep_i = 1'b0;
   logic         windowed_wdt_i = 1'b0;
   logic         sysclk_is_low_power_rc_osc_i = 1'b0;
   logic         pps_unlocked_i = 1'b0;
   logic         config_valid_o;
   osc_cfg_t     osc_cfg_o;
   protect_cfg_t protect_cfg_o;
   lowpwr_cfg_t  lowpwr_cfg_o;
   logic [23:0]  w2, w3, w4;
   logic [31:0]  rd;
   logic         lock, ds_req;
   int           bad_count = 0, total_checks = 0, seed = 44297;
   int           divs [8] = '{1, 2, 3, 4, 5, 6, 8, 12};
   int           win [4] = '{6, 4, 3, 2};

   // Free running 10 MHz clock
   always #50 clk_i = ~clk_i;

   config_word_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
      .wb_rsp_o(wb_rsp_o), .nvm_req_o(nvm_req_o), .nvm_index_o(nvm_index_o),
      .nvm_ack_i(nvm_ack_i), .nvm_data_i(nvm_data_i), .large_package_i(large_package_i),
      .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i), .windowed_wdt_i(windowed_wdt_i),
      .sysclk_is_low_power_rc_osc_i(sysclk_is_low_power_rc_osc_i), .pps_unlocked_i(pps_unlocked_i),
      .config_valid_o(config_valid_o), .osc_cfg_o(osc_cfg_o), .protect_cfg_o(protect_cfg_o),
      .lowpwr_cfg_o(lowpwr_cfg_o));

   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Bounded wait for a level, sampled at the falling edge
   task automatic wait_for(ref logic sig);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      if (sig !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask

   // Classic single cycle, held until ack is seen
   task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_i <= '{1'b1, 1'b1, we, adr, 4'hF, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_rsp_o.ack !== 1'b1 && n < 40);
      if (wb_rsp_o.ack !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
      rd = wb_rsp_o.dat;
      wb_req_i <= '0;
   endtask

   // Serve the three word reads; data lines change once released
   task automatic load();
      for (int i = 1; i <= 3; i++) begin
         wait_for(nvm_req_o);
         check("index", nvm_index_o, i);
         @(posedge clk_i);
         nvm_ack_i <= 1'b1;
         nvm_data_i <= (i == 1) ? w2 : (i == 2) ? w3 : w4;
         @(posedge clk_i);
         nvm_ack_i <= 1'b0;
         nvm_data_i <= ~nvm_data_i;
         @(negedge clk_i);
      end
      wait_for(config_valid_o);
      @(posedge clk_i);
      @(posedge clk_i);
   endtask

   // Random run-time levels, then every decoded field against the model
   task automatic check_cfg();
      logic [1:0]   pm;
      logic [3:0]   pd;
      logic [6:0]   pg;
      clkout_mode_t ck;
      wdt_clock_t   wc;
      @(posedge clk_i);
      {sleep_i, deep_sleep_i, windowed_wdt_i, sysclk_is_low_power_rc_osc_i} <= 4'($random(seed));
      @(posedge clk_i);
      @(negedge clk_i);
      pm = w2[1:0];
      pd = w4[13:10];
      pg = w3[6:0];
      ck = (pm == 2'h3 || pm == 2'h0) ? (w2[5] ? PIN_INSTR_CLOCK : PIN_PORT_IO) : PIN_OSCILLATOR;
      case (w2[4:3])
         2'h3: wc = WCLK_LOW_POWER_RC;
         2'h2: wc = (windowed_wdt_i && !sysclk_is_low_power_rc_osc_i && !sleep_i) ? WCLK_FAST_RC : WCLK_LOW_POWER_RC;
         2'h1: wc = WCLK_SECONDARY;
         default: wc = sleep_i ? WCLK_LOW_POWER_RC : WCLK_SYSTEM;
      endcase
      if (!w2[13]) wc = WCLK_LOW_POWER_RC;
      check("clkout", osc_cfg_o.clkout_pin_select, ck);
      check("posc", osc_cfg_o.primary_osc_mode, pm);
      check("watchdog_clock_select", osc_cfg_o.watchdog_clock, wc);
      check("secondary_osc", {osc_cfg_o.secondary_osc_crystal, osc_cfg_o.secondary_clock_digital}, {w3[8], !w3[8]});
      check("bor", osc_cfg_o.brownout_active, deep_sleep_i ? w4[6] : w3[12]);
      check("window", osc_cfg_o.window_eighths, win[w3[10:9]]);
      check("segen", protect_cfg_o.segment_enable, !w3[13]);
      if (!w3[13]) begin
         check("seglo", protect_cfg_o.segment_low_addr, w3[15] ? {pg, 9'h000} : 16'h0);
         check("seghi", protect_cfg_o.segment_high_addr, w3[15] ? {LAST_PAGE, 9'h1FF} : {pg, 9'h1FF});
      end
      check("cfglock", protect_cfg_o.config_page_locked, !w3[13] && (!w3[14] || w3[15] || pg == LAST_PAGE));
      check("oneway", lowpwr_cfg_o.pinselect_oneway_lock, w4[15]);
      check("pslock", lowpwr_cfg_o.pinselect_lock, lock);
      check("i2c", lowpwr_cfg_o.i2c_two_pin_route, large_package_i ? w4[14] : 1'b1);
      check("pllres", lowpwr_cfg_o.pll_reserved, pd[3] && pd != 4'hF);
      check("usb_pll_prescale", lowpwr_cfg_o.pll_divisor, pd[3] ? 0 : divs[pd[2:0]]);
      if (!pd[3] || pd == 4'hF) check("pllen", lowpwr_cfg_o.pll_enable, !pd[3]);
      check("battery_rtc_run", lowpwr_cfg_o.battery_rtc_run, w4[9]);
      check("dsallow", lowpwr_cfg_o.deep_sleep_allowed, w4[8] && ds_req);
      check("dswdt", {lowpwr_cfg_o.deep_sleep_wdog_enable, lowpwr_cfg_o.deep_sleep_wdog_low_power_rc_osc}, {w4[7], w4[5]});
      check("dsexp", lowpwr_cfg_o.deep_sleep_wdog_exp, w4[4:0] + 5);
   endtask

   // Lock handling, ignored word write, readback and an unmapped address
   task automatic regs();
      logic [31:0] exp [5];
      logic [4:0]  ofs [5];
      wb(1'b1, OFS_WORD_TWO, 32'h0);
      pps_unlocked_i <= 1'b1;
      wb(1'b1, OFS_CONTROL, 32'h2);
      lock = 1'b1;
      wb(1'b1, OFS_CONTROL, 32'h1);
      lock = w4[15];
      ds_req = 1'b1;
      pps_unlocked_i <= 1'b0;
      wb(1'b1, OFS_CONTROL, {30'h0, !lock, 1'b1});
      check_cfg();
      ofs = '{OFS_WORD_TWO, OFS_WORD_PROTECT, OFS_WORD_LOWPOWER, OFS_STATUS, 5'h14};
      exp = '{{8'h00, UNIMPL_UPPER, w2[15:0]}, {8'h00, UNIMPL_UPPER, w3[15:0]},
              {8'h00, UNIMPL_UPPER, w4[15:0]}, {30'h0, lock, 1'b1}, 32'h0};
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, ofs[i], 32'h0);
         check("read", rd, exp[i]);
      end
      wb(1'b0, OFS_CONTROL, 32'h0);
      check("control", rd, {30'h0, lock, ds_req});
   endtask

   // Sixteen resets, each loading fresh words that sweep every 2-bit and 4-bit field code
   initial begin
      for (int run = 0; run < 16; run++) begin
         w2 = 24'($random(seed));
         w3 = 24'($random(seed));
         w4 = 24'($random(seed));
         w2[4:0] = {run[3:2], w2[2], run[1:0]};
         w3[10:9] = run[1:0];
         w3[13] = run[3] & run[0];
         if (run == 5 || run == 10) w3[6:0] = LAST_PAGE;
         w4[13:10] = run[3:0];
         w4[4:0] = (run == 15) ? 5'h1F : 5'(run);
         large_package_i <= run[1];
         rst_i <= 1'b1;
         repeat (20) @(posedge clk_i);
         rst_i <= 1'b0;
         lock = 1'b0;
         ds_req = 1'b0;
         load();
         repeat (6) check_cfg();
         regs();
         $display("run %0d done", run);
      end
      end_of_test();
   end
endmodule
